// file: bench/ata_security_set_features_tb.sv
// Self-checking bench for the security and set-features decoder
`timescale 1ns/1ns
`default_nettype none
module ata_security_set_features_tb;
   typedef struct {logic [15:0] v; logic [15:0] m;} atasf_note_s;
   localparam logic [35:0] SF_TAB [19] = '{36'h0_02_00_FE4C, 36'h0_01_00_FECC, 36'h0_81_00_FE4C,
      36'h0_AA_00_FE5C, 36'h0_55_00_FE4C, 36'h0_66_00_FE44, 36'h0_CC_00_FE4C, 36'h0_05_7F_7F6C,
      36'h0_05_80_806C, 36'h1_05_00_806C, 36'h1_05_FF_806C, 36'h0_69_00_806C, 36'h0_96_00_806C,
      36'h0_97_00_806C, 36'h1_42_00_806C, 36'h0_09_00_806E, 36'h0_89_00_806C, 36'h0_0A_00_806D,
      36'h0_8A_00_806C};
   localparam logic [23:0] XM_TAB [6] = '{24'h00_10_FF, 24'h01_00_FF, 24'h0C_90_FF, 24'h44_9C_FF,
      24'h22_92_FF, 24'h42_9A_FF};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hard_reset = 1'b0;
   logic flush_done = 1'b0;
   logic [1:0] if_mode = 2'h2;
   logic [3:0] addr;
   logic [15:0] wdata, rdata;
   logic wr, rd, iordy_en, standby_allowed, locked, wide_io_n, flush_req;
   logic rd_q = 1'b0;
   logic wide_q = 1'b1;
   logic [7:0] ku, km, kx;
   atasf_pkg::atasf_cfg_s cfg;
   int err_total = 0;
   int samples_checked = 0;
   atasf_note_s notes[$];
   atasf_note_s n;

   always #4 clk = ~clk;
   atasf_host atasf_host_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   atasf_core atasf_core_inst (.clk(clk), .reset_n(reset_n), .hard_reset(hard_reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .if_mode(if_mode), .flush_req(flush_req),
      .flush_done(flush_done), .cfg(cfg), .iordy_en(iordy_en), .standby_allowed(standby_allowed),
      .locked(locked), .wide_io_indication_n(wide_io_n));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Mismatches %0d, comparisons %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Read data answers the previous read; bit 0 also shows its wide indication
   always @(posedge clk) begin
      if (rd_q) begin
         n = notes.pop_front();
         check((rdata ^ {15'h0000, ~wide_q}) & n.m, n.v & n.m);
      end
      rd_q <= rd;
      wide_q <= wide_io_n;
   end
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] v, input logic [15:0] m);
      notes.push_back('{v: v, m: m});
      atasf_host_inst.bus_rd(a);
   endtask
   task automatic stat(input logic ab);
      rd_chk(atasf_pkg::A_CMD, {9'h000, 1'b1, 5'h00, ab}, 16'h00C9);
   endtask
   task automatic sf(input logic [7:0] f, input logic [7:0] c, input logic ab);
      atasf_host_inst.set_features(f, c);
      stat(ab);
   endtask
   task automatic pw(input logic [7:0] cmd, input logic [15:0] ctl, input logic [7:0] key,
      input logic ab, input bit nd);
      atasf_host_inst.bus_wr(atasf_pkg::A_CMD, {8'h00, cmd});
      for (int i = 0; i < 256 && !nd; i++) begin
         atasf_host_inst.bus_wr(atasf_pkg::A_DATA, i == 0 ? ctl : (i <= 16 ? {key, 8'(i)} : 16'h0000));
      end
      stat(ab);
   endtask
   task automatic hrst();
      @(posedge clk);
      hard_reset <= 1'b1;
      @(posedge clk);
      hard_reset <= 1'b0;
   endtask

   initial begin
      #(8 * 60000);
      err_total++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h59624A27));
      ku = 8'($urandom());
      km = ku ^ 8'h5A;
      kx = ku ^ 8'hA5;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rd_chk(atasf_pkg::A_MODE, 16'h0010, 16'h00FF);
      rd_chk(atasf_pkg::A_SEC, 16'h3228, 16'hFF3F);
      rd_chk(4'h3, 16'h0000, 16'hFFFF);
      atasf_host_inst.bus_wr(4'hC, 16'($urandom()));
      rd_chk(atasf_pkg::A_FLAGS, 16'hFE4C, 16'hFFFF);
      atasf_host_inst.set_features(atasf_pkg::SF_WC_OFF, 8'h00);
      repeat ($urandom_range(1, 9)) @(posedge clk);
      rd_chk(atasf_pkg::A_CMD, 16'h0080, 16'h0080);
      flush_done <= 1'b1;
      @(posedge clk);
      flush_done <= 1'b0;
      stat(1'b0);
      rd_chk(atasf_pkg::A_FLAGS, 16'h0000, 16'h0040);
      foreach (SF_TAB[i]) begin
         sf(SF_TAB[i][31:24], SF_TAB[i][23:16], SF_TAB[i][32]);
         rd_chk(atasf_pkg::A_FLAGS, SF_TAB[i][15:0], 16'hFFFF);
         rd_chk(atasf_pkg::A_DATA, {15'h0000, ~SF_TAB[i][7]}, 16'hFFFF);
         check({15'h0000, standby_allowed}, {15'h0000, ~(SF_TAB[i][5] & SF_TAB[i][15])});
      end
      sf(atasf_pkg::SF_APM_OFF, 8'h00, 1'b0);
      rd_chk(atasf_pkg::A_FLAGS, 16'h004C, 16'h00FF);
      foreach (XM_TAB[i]) begin
         sf(atasf_pkg::SF_XFER, XM_TAB[i][23:16], 1'b0);
         rd_chk(atasf_pkg::A_MODE, {8'h00, XM_TAB[i][15:8]}, {8'h00, XM_TAB[i][7:0]});
      end
      if_mode <= 2'h0;
      sf(atasf_pkg::SF_XFER, 8'h21, 1'b1);
      rd_chk(atasf_pkg::A_MODE, 16'h009A, 16'h000F);
      if_mode <= 2'h2;
      sf(atasf_pkg::SF_CUR, 8'h06, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0600, 16'hFF00);
      rd_chk(atasf_pkg::A_CYLLO, 16'h0005, 16'h00FF);
      rd_chk(atasf_pkg::A_CYLHI, 16'h0032, 16'h00FF);
      sf(atasf_pkg::SF_CUR, 8'h01, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0500, 16'hFF00);
      sf(atasf_pkg::SF_ECC4, 8'h00, 1'b0);
      atasf_host_inst.bus_wr(atasf_pkg::A_CTRL, 16'h0004);
      rd_chk(atasf_pkg::A_FLAGS, 16'hFE4C, 16'hFFFF);
      sf(atasf_pkg::SF_POR_OFF, 8'h00, 1'b0);
      sf(atasf_pkg::SF_RLA_ON, 8'h00, 1'b0);
      atasf_host_inst.bus_wr(atasf_pkg::A_CTRL, 16'h0004);
      rd_chk(atasf_pkg::A_FLAGS, 16'h0014, 16'h001C);
      pw(8'hF1, 16'h0001, km, 1'b0, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0028, 16'h003E);
      pw(8'hF1, 16'h0000, ku, 1'b0, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0028, 16'h003E);
      hrst();
      rd_chk(atasf_pkg::A_SEC, 16'h002D, 16'h003F);
      pw(8'hF2, 16'h0000, kx, 1'b1, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0025, 16'h003F);
      pw(8'hF2, 16'h0001, km, 1'b0, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0021, 16'h003F);
      pw(8'hF2, 16'h0000, kx, 1'b1, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0021, 16'h003F);
      pw(8'hF1, 16'h0100, ku, 1'b0, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0023, 16'h003F);
      hrst();
      pw(8'hF2, 16'h0001, km, 1'b1, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h002F, 16'h003F);
      repeat (5) pw(8'hF2, 16'h0000, kx, 1'b1, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h0007, 16'h003F);
      pw(8'hF2, 16'h0000, ku, 1'b1, 1'b1);
      rd_chk(atasf_pkg::A_SEC, 16'h0007, 16'h003F);
      hrst();
      pw(8'hF2, 16'h0000, ku, 1'b0, 1'b0);
      rd_chk(atasf_pkg::A_SEC, 16'h002B, 16'h003F);
      repeat (3) @(posedge clk);
      wrap_up();
   end
endmodule
`default_nettype wire

// file: bench/atasf_core_monitor.sv
// Port-level checker for the security and set-features decoder
`timescale 1ns/1ns
`default_nettype none
module atasf_core_monitor (
   input wire logic clk, // Clock
   input wire logic reset_n, // Async reset, active low
   input wire logic hard_reset, // Hardware reset pulse
   input wire logic [3:0] addr, // Register address
   input wire logic [15:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   input wire logic [15:0] rdata, // Read data
   input wire logic [1:0] if_mode, // Interface mode
   input wire logic flush_req, // Flush request
   input wire logic flush_done, // Flush finished
   input wire atasf_pkg::atasf_cfg_s cfg, // Current settings
   input wire logic iordy_en, // Ready handshake in use
   input wire logic standby_allowed, // Standby permitted
   input wire logic locked, // Media locked
   input wire logic wide_io_indication_n // Wide access, active low
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_rdata_idle;
      !$past(rd) |-> rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_wide_io;
      (wr || rd) && addr == atasf_pkg::A_DATA |-> wide_io_indication_n == cfg.eight_bit;
   endproperty
   a_wide_io: assert property (p_wide_io) else $error("wide access indication wrong");
   property p_flush_hold;
      flush_req && !flush_done && !hard_reset |=> flush_req;
   endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("flush ended early");
   property p_iordy;
      cfg.pio_mode >= atasf_pkg::PIO_RDY_MIN |-> iordy_en;
   endproperty
   a_iordy: assert property (p_iordy) else $error("ready handshake off at fast mode");
   property p_modes;
      1'b1 |-> cfg.pio_mode <= atasf_pkg::PIO_MAX && cfg.dma_mode <=
         (cfg.dma_type == atasf_pkg::ATASF_UDMA ? atasf_pkg::UDMA_MAX : atasf_pkg::MDMA_MAX);
   endproperty
   a_modes: assert property (p_modes) else $error("mode selection out of range");
   property p_standby;
      1'b1 |-> standby_allowed == !(cfg.apm_en && cfg.apm_level >= atasf_pkg::APM_NOSTBY);
   endproperty
   a_standby: assert property (p_standby) else $error("standby permission wrong");
   property p_apm_lvl;
      cfg.apm_en |-> cfg.apm_level != 8'h00 && cfg.apm_level != 8'hFF;
   endproperty
   a_apm_lvl: assert property (p_apm_lvl) else $error("reserved power level in use");
   property p_cur;
      1'b1 |-> cfg.cur_lim >= atasf_pkg::CUR_MIN && cfg.cur_lim <= atasf_pkg::CUR_MAX;
   endproperty
   a_cur: assert property (p_cur) else $error("current limit out of range");
   property p_lock_rise;
      $rose(locked) |-> $past(hard_reset);
   endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock set without reset");
   property p_cfg_cause;
      $changed(cfg) |-> $past(wr) || $past(hard_reset) || $past(flush_req);
   endproperty
   a_cfg_cause: assert property (p_cfg_cause) else $error("settings changed unprompted");
endmodule
bind atasf_core atasf_core_monitor atasf_core_monitor_inst (.clk(clk), .reset_n(reset_n),
   .hard_reset(hard_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .if_mode(if_mode), .flush_req(flush_req), .flush_done(flush_done), .cfg(cfg),
   .iordy_en(iordy_en), .standby_allowed(standby_allowed), .locked(locked),
   .wide_io_indication_n(wide_io_indication_n));
`default_nettype wire

// file: bench/atasf_host.sv
// Host controller model driving the task-file bus
`timescale 1ns/1ns
`default_nettype none
module atasf_host (
   input wire logic clk, // Bus clock
   output logic [3:0] addr, // Register address
   output logic [15:0] wdata, // Write data
   output logic wr, // Write strobe
   output logic rd // Read strobe
);
   initial begin
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask
   task automatic bus_rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic set_features(input logic [7:0] f, input logic [7:0] c);
      bus_wr(atasf_pkg::A_FEAT, {8'h00, f});
      bus_wr(atasf_pkg::A_SCNT, {8'h00, c});
      bus_wr(atasf_pkg::A_CMD, {8'h00, atasf_pkg::CMD_SETF});
   endtask
endmodule
`default_nettype wire

// file: rtl/atasf_core.sv
// Security unlock/password and set-features command decoder
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module atasf_core (
   input wire logic clk, // 125 MHz clock
   input wire logic reset_n, // Power-on reset, async, active low
   input wire logic hard_reset, // Hardware reset pulse
   input wire logic [3:0] addr, // Register address
   input wire logic [15:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [15:0] rdata, // Read data, cycle after rd
   input wire logic [1:0] if_mode, // Interface mode
   output logic flush_req, // Cache flush request
   input wire logic flush_done, // Cache flush finished
   output atasf_pkg::atasf_cfg_s cfg, // Current feature settings
   output logic iordy_en, // Ready handshake in use
   output logic standby_allowed, // Standby spin-down permitted
   output logic locked, // Media locked
   output logic wide_io_indication_n // 16-bit data access, active low
);
   atasf_pkg::atasf_state_e state_r;
   atasf_pkg::atasf_cfg_s cfg_r, cfg_sf;
   logic [7:0] feat_r, scnt_r, cyllo_r, cylhi_r;
   logic err_r, abrt_r, op_unlock_r, id_master_r, lvl_max_r;
   logic mis_u_r, mis_m_r, byte_hi_r;
   logic [7:0] widx_r, lo_byte_r;
   logic sec_en_r, sec_max_r, locked_r;
   logic [2:0] tries_r;
   logic [15:0] rdata_r;
   logic [15:0] user_pw [atasf_pkg::PW_WORDS];
   logic [15:0] master_pw [atasf_pkg::PW_WORDS];
   logic sf_ok, sf_flush;

   // Bus decode
   wire idle = state_r == atasf_pkg::ATASF_IDLE;
   wire cmd_wr = wr & (addr == atasf_pkg::A_CMD) & idle;
   wire srst = wr & (addr == atasf_pkg::A_CTRL) & wdata[atasf_pkg::CT_SRST];
   wire data_acc = (wr | rd) & (addr == atasf_pkg::A_DATA);
   wire data_wr = wr & (addr == atasf_pkg::A_DATA) & (state_r == atasf_pkg::ATASF_XFER);
   // In 8-bit mode two byte writes form one word
   wire word_v = data_wr & (~cfg_r.eight_bit | byte_hi_r);
   wire [15:0] word = cfg_r.eight_bit ? {wdata[7:0], lo_byte_r} : wdata;
   wire last_word = word_v & (widx_r == atasf_pkg::LAST_WORD);
   wire in_pw = word_v & (widx_r >= atasf_pkg::PW_FIRST) & (widx_r <= atasf_pkg::PW_LAST);
   wire [3:0] pw_idx = 4'(widx_r - atasf_pkg::PW_FIRST);
   wire pw_we_u = in_pw & ~op_unlock_r & ~id_master_r;
   wire pw_we_m = in_pw & ~op_unlock_r & id_master_r;
   wire tries_out = tries_r == 3'h0;

   // Command issue decode
   wire iss_setpw = cmd_wr & (wdata[7:0] == atasf_pkg::CMD_SETPW);
   wire iss_unlock = cmd_wr & (wdata[7:0] == atasf_pkg::CMD_UNLOCK) & ~tries_out;
   wire iss_setf = cmd_wr & (wdata[7:0] == atasf_pkg::CMD_SETF);
   wire iss_xfer = iss_setpw | iss_unlock;
   wire iss_abort = cmd_wr & ~iss_xfer & ~(iss_setf & sf_ok);

   // Unlock outcome at end of the sector
   wire ul_end = last_word & op_unlock_r;
   wire ul_refuse = id_master_r & sec_max_r;
   wire ul_mis = id_master_r ? mis_m_r : mis_u_r;
   wire ul_abort = ul_end & (ul_refuse | ul_mis);
   wire ul_pass = ul_end & ~ul_refuse & ~ul_mis;
   wire ul_dec = ul_end & ~ul_refuse & ul_mis & locked_r;

   wire xt_mdma_bad = (if_mode == atasf_pkg::IF_MEM) | (if_mode == atasf_pkg::IF_IO);

   // Set-features decode, settings move only when accepted
   always_comb begin
      cfg_sf = cfg_r;
      sf_ok = 1'b1;
      sf_flush = 1'b0;
      unique case (feat_r)
         atasf_pkg::SF_8B_ON: cfg_sf.eight_bit = 1'b1;
         atasf_pkg::SF_8B_OFF: cfg_sf.eight_bit = 1'b0;
         atasf_pkg::SF_WC_ON: cfg_sf.wcache = 1'b1;
         atasf_pkg::SF_WC_OFF: begin
            cfg_sf.wcache = 1'b0;
            sf_flush = 1'b1;
         end
         atasf_pkg::SF_XFER: begin
            unique case (scnt_r[7:3])
               atasf_pkg::XT_PIO_DEF: begin
                  // Only 000b and 001b are defined here
                  cfg_sf.pio_mode = 3'h0;
                  cfg_sf.iordy_dis = scnt_r[2:0] == atasf_pkg::XM_NORDY;
                  sf_ok = scnt_r[2:0] == atasf_pkg::XM_DEF || scnt_r[2:0] == atasf_pkg::XM_NORDY;
               end
               atasf_pkg::XT_PIO_FC: begin
                  cfg_sf.pio_mode = scnt_r[2:0];
                  cfg_sf.iordy_dis = 1'b0;
                  sf_ok = scnt_r[2:0] <= atasf_pkg::PIO_MAX;
               end
               atasf_pkg::XT_MDMA: begin
                  cfg_sf.dma_type = atasf_pkg::ATASF_MDMA;
                  cfg_sf.dma_mode = scnt_r[2:0];
                  sf_ok = (scnt_r[2:0] <= atasf_pkg::MDMA_MAX) & ~xt_mdma_bad;
               end
               atasf_pkg::XT_UDMA: begin
                  cfg_sf.dma_type = atasf_pkg::ATASF_UDMA;
                  cfg_sf.dma_mode = scnt_r[2:0];
                  sf_ok = scnt_r[2:0] <= atasf_pkg::UDMA_MAX;
               end
               default: sf_ok = 1'b0;
            endcase
         end
         atasf_pkg::SF_APM_ON: begin
            cfg_sf.apm_en = 1'b1;
            cfg_sf.apm_level = scnt_r;
            sf_ok = (scnt_r != atasf_pkg::APM_RSV_LO) & (scnt_r != atasf_pkg::APM_RSV_HI);
         end
         atasf_pkg::SF_APM_OFF: cfg_sf.apm_en = 1'b0;
         atasf_pkg::SF_EXT_ON: cfg_sf.ext_pwr = 1'b1;
         atasf_pkg::SF_EXT_OFF: cfg_sf.ext_pwr = 1'b0;
         atasf_pkg::SF_PL1_ON: cfg_sf.pl1 = 1'b1;
         atasf_pkg::SF_PL1_OFF: cfg_sf.pl1 = 1'b0;
         atasf_pkg::SF_RLA_OFF: cfg_sf.lookahead = 1'b0;
         atasf_pkg::SF_RLA_ON: cfg_sf.lookahead = 1'b1;
         atasf_pkg::SF_POR_OFF: cfg_sf.revert = 1'b0;
         atasf_pkg::SF_POR_ON: cfg_sf.revert = 1'b1;
         atasf_pkg::SF_NOP_A, atasf_pkg::SF_NOP_B, atasf_pkg::SF_NOP_C: sf_ok = 1'b1;
         atasf_pkg::SF_CUR: begin
            // Out-of-range limits clamp to the nearest supported end
            if (scnt_r < atasf_pkg::CUR_MIN) begin
               cfg_sf.cur_lim = atasf_pkg::CUR_MIN;
            end else if (scnt_r > atasf_pkg::CUR_MAX) begin
               cfg_sf.cur_lim = atasf_pkg::CUR_MAX;
            end else begin
               cfg_sf.cur_lim = scnt_r;
            end
         end
         atasf_pkg::SF_ECC4: cfg_sf.ecc4 = 1'b1;
         default: sf_ok = 1'b0;
      endcase
   end

   // Command state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= atasf_pkg::ATASF_IDLE;
      end else if (hard_reset | srst) begin
         state_r <= atasf_pkg::ATASF_IDLE;
      end else if (iss_xfer) begin
         state_r <= atasf_pkg::ATASF_XFER;
      end else if (iss_setf & sf_ok & sf_flush) begin
         state_r <= atasf_pkg::ATASF_FLUSH;
      end else if (last_word | (state_r == atasf_pkg::ATASF_FLUSH & flush_done)) begin
         state_r <= atasf_pkg::ATASF_IDLE;
      end
   end

   // Feature settings
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= atasf_pkg::CFG_DEFAULT;
      end else if (hard_reset | (srst & cfg_r.revert)) begin
         cfg_r <= atasf_pkg::CFG_DEFAULT;
      end else if (iss_setf & sf_ok) begin
         cfg_r <= cfg_sf;
      end
   end

   // Task-file registers written by the host
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         feat_r <= 8'h00;
         scnt_r <= 8'h00;
         cyllo_r <= 8'h00;
         cylhi_r <= 8'h00;
      end else begin
         if (wr & idle & (addr == atasf_pkg::A_FEAT)) feat_r <= wdata[7:0];
         if (wr & idle & (addr == atasf_pkg::A_SCNT)) scnt_r <= wdata[7:0];
         if (iss_setf & sf_ok & (feat_r == atasf_pkg::SF_CUR)) begin
            cyllo_r <= atasf_pkg::CUR_MIN;
            cylhi_r <= atasf_pkg::CUR_MAX;
         end else begin
            if (wr & idle & (addr == atasf_pkg::A_CYLLO)) cyllo_r <= wdata[7:0];
            if (wr & idle & (addr == atasf_pkg::A_CYLHI)) cylhi_r <= wdata[7:0];
         end
      end
   end

   // Completion status
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         err_r <= 1'b0;
         abrt_r <= 1'b0;
      end else if (hard_reset | srst | cmd_wr) begin
         err_r <= iss_abort;
         abrt_r <= iss_abort;
      end else if (ul_end) begin
         err_r <= ul_abort;
         abrt_r <= ul_abort;
      end
   end

   // Sector word collection and compare
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         widx_r <= 8'h00;
         byte_hi_r <= 1'b0;
         lo_byte_r <= 8'h00;
         op_unlock_r <= 1'b0;
         id_master_r <= 1'b0;
         lvl_max_r <= 1'b0;
         mis_u_r <= 1'b0;
         mis_m_r <= 1'b0;
      end else if (iss_xfer) begin
         widx_r <= 8'h00;
         byte_hi_r <= 1'b0;
         op_unlock_r <= iss_unlock;
         mis_u_r <= 1'b0;
         mis_m_r <= 1'b0;
      end else if (data_wr) begin
         byte_hi_r <= cfg_r.eight_bit & ~byte_hi_r;
         if (~byte_hi_r) lo_byte_r <= wdata[7:0];
         if (word_v) begin
            widx_r <= 8'(widx_r + 8'h01);
            if (widx_r == 8'h00) begin
               id_master_r <= word[atasf_pkg::PW_ID_BIT];
               lvl_max_r <= word[atasf_pkg::PW_LVL_BIT];
            end
            if (in_pw & (word != user_pw[pw_idx])) mis_u_r <= 1'b1;
            if (in_pw & (word != master_pw[pw_idx])) mis_m_r <= 1'b1;
         end
      end
   end

   // Password storage, kept across hardware reset
   genvar g;
   generate
      for (g = 0; g < atasf_pkg::PW_WORDS; g++) begin : g_pw
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               user_pw[g] <= 16'h0000;
               master_pw[g] <= 16'h0000;
            end else begin
               if (pw_we_u & (pw_idx == 4'(g))) user_pw[g] <= word;
               if (pw_we_m & (pw_idx == 4'(g))) master_pw[g] <= word;
            end
         end
      end
   endgenerate

   // Security state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_en_r <= 1'b0;
         sec_max_r <= 1'b0;
         locked_r <= 1'b0;
         tries_r <= atasf_pkg::TRIES_INIT;
      end else if (hard_reset) begin
         locked_r <= sec_en_r;
         tries_r <= atasf_pkg::TRIES_INIT;
      end else begin
         if (last_word & ~op_unlock_r & ~id_master_r) begin
            sec_en_r <= 1'b1;
            sec_max_r <= lvl_max_r;
         end
         if (ul_pass) locked_r <= 1'b0;
         if (ul_dec) tries_r <= 3'(tries_r - 3'h1);
      end
   end

   // Read mux
   wire [7:0] status = {~idle & (state_r == atasf_pkg::ATASF_FLUSH), idle, 3'h0,
      state_r == atasf_pkg::ATASF_XFER, 2'h0} | {7'h00, err_r};
   wire [15:0] rd_mux =
      (addr == atasf_pkg::A_FEAT) ? {13'h0000, abrt_r, 2'h0} :
      (addr == atasf_pkg::A_SCNT) ? {8'h00, scnt_r} :
      (addr == atasf_pkg::A_CYLLO) ? {8'h00, cyllo_r} :
      (addr == atasf_pkg::A_CYLHI) ? {8'h00, cylhi_r} :
      (addr == atasf_pkg::A_CMD) ? {8'h00, status} :
      (addr == atasf_pkg::A_MODE) ? {8'h00, cfg_r.pio_mode, iordy_en, cfg_r.dma_type, cfg_r.dma_mode} :
      (addr == atasf_pkg::A_FLAGS) ? {cfg_r.apm_level, cfg_r.eight_bit, cfg_r.wcache, cfg_r.apm_en,
         cfg_r.lookahead, cfg_r.revert, cfg_r.ecc4, cfg_r.ext_pwr, cfg_r.pl1} :
      (addr == atasf_pkg::A_SEC) ? {cfg_r.cur_lim, 2'h0, tries_r, locked_r, sec_max_r, sec_en_r} :
      16'h0000;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rd ? rd_mux : 16'h0000;
      end
   end

   assign rdata = rdata_r;
   assign cfg = cfg_r;
   assign flush_req = state_r == atasf_pkg::ATASF_FLUSH;
   assign iordy_en = ~cfg_r.iordy_dis | (cfg_r.pio_mode >= atasf_pkg::PIO_RDY_MIN);
   assign standby_allowed = ~cfg_r.apm_en | (cfg_r.apm_level < atasf_pkg::APM_NOSTBY);
   assign locked = locked_r;
   assign wide_io_indication_n = ~(data_acc & ~cfg_r.eight_bit);
endmodule
`default_nettype wire

// file: rtl/atasf_pkg.sv
// Constants, types and field layout of the security and set-features decoder
// Function
// - User pw, high level: arm lock, both unlock
// - User pw, maximum level: only user unlocks
// - Master pw set leaves lock, level unchanged
// - Unlock F2h: master refused at maximum level
// - Counter preset five, mismatch while locked decrements
// - Counter zero aborts unlock until reset
// - Unlock while unlocked keeps counter
// - Set features EFh decodes feature, count
// - 8-bit mode: low byte, no wide indication
// - Write cache on/off, flush before completion
// - Transfer mode: type bits 7:3, mode 2:0
// - Zero value default PIO, 001b drops ready
// - Exactly one PIO and DMA mode always
// - Ultra and multiword DMA exclude each other
// - No multiword DMA in card memory/IO modes
// - Accept every mode up to highest supported
// - Ready handshake on at PIO mode 3+
// - APM 05h loads level, 85h disables
// - 55h/AAh look-ahead, 66h/CCh soft-reset revert
// - 69h, 96h, 97h complete as no-ops
// - 9Ah sets current limit from count
// - BBh adds 4 check bytes long commands
// - Current value quarter mA, report min/max
// - APM 80h+ forbids standby; 00h, FFh reserved
package atasf_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   // Register offsets
   localparam logic [3:0] A_DATA = 4'h0;
   localparam logic [3:0] A_FEAT = 4'h1;
   localparam logic [3:0] A_SCNT = 4'h2;
   localparam logic [3:0] A_CYLLO = 4'h4;
   localparam logic [3:0] A_CYLHI = 4'h5;
   localparam logic [3:0] A_CMD = 4'h7;
   localparam logic [3:0] A_MODE = 4'h8;
   localparam logic [3:0] A_FLAGS = 4'h9;
   localparam logic [3:0] A_SEC = 4'hA;
   localparam logic [3:0] A_CTRL = 4'hB;
   // Status, error, control and password-word bit positions
   localparam int unsigned ST_BSY = 7;
   localparam int unsigned ST_DRDY = 6;
   localparam int unsigned ST_DRQ = 3;
   localparam int unsigned ST_ERR = 0;
   localparam int unsigned ER_ABRT = 2;
   localparam int unsigned CT_SRST = 2;
   localparam int unsigned PW_ID_BIT = 0;
   localparam int unsigned PW_LVL_BIT = 8;
   // Commands
   localparam logic [7:0] CMD_SETPW = 8'hF1;
   localparam logic [7:0] CMD_UNLOCK = 8'hF2;
   localparam logic [7:0] CMD_SETF = 8'hEF;
   // Set-features subcommands
   localparam logic [7:0] SF_8B_ON = 8'h01;
   localparam logic [7:0] SF_8B_OFF = 8'h81;
   localparam logic [7:0] SF_WC_ON = 8'h02;
   localparam logic [7:0] SF_WC_OFF = 8'h82;
   localparam logic [7:0] SF_XFER = 8'h03;
   localparam logic [7:0] SF_APM_ON = 8'h05;
   localparam logic [7:0] SF_APM_OFF = 8'h85;
   localparam logic [7:0] SF_EXT_ON = 8'h09;
   localparam logic [7:0] SF_EXT_OFF = 8'h89;
   localparam logic [7:0] SF_PL1_ON = 8'h0A;
   localparam logic [7:0] SF_PL1_OFF = 8'h8A;
   localparam logic [7:0] SF_RLA_OFF = 8'h55;
   localparam logic [7:0] SF_RLA_ON = 8'hAA;
   localparam logic [7:0] SF_POR_OFF = 8'h66;
   localparam logic [7:0] SF_POR_ON = 8'hCC;
   localparam logic [7:0] SF_NOP_A = 8'h69;
   localparam logic [7:0] SF_NOP_B = 8'h96;
   localparam logic [7:0] SF_NOP_C = 8'h97;
   localparam logic [7:0] SF_CUR = 8'h9A;
   localparam logic [7:0] SF_ECC4 = 8'hBB;
   // Transfer types in count bits 7:3, modes in bits 2:0 and mode limits
   localparam logic [4:0] XT_PIO_DEF = 5'h00;
   localparam logic [4:0] XT_PIO_FC = 5'h01;
   localparam logic [4:0] XT_MDMA = 5'h04;
   localparam logic [4:0] XT_UDMA = 5'h08;
   localparam logic [2:0] XM_DEF = 3'h0;
   localparam logic [2:0] XM_NORDY = 3'h1;
   localparam logic [2:0] PIO_MAX = 3'h4;
   localparam logic [2:0] MDMA_MAX = 3'h2;
   localparam logic [2:0] UDMA_MAX = 3'h4;
   localparam logic [2:0] PIO_RDY_MIN = 3'h3;
   // Power management and current limits
   localparam logic [7:0] APM_RSV_LO = 8'h00;
   localparam logic [7:0] APM_RSV_HI = 8'hFF;
   localparam logic [7:0] APM_NOSTBY = 8'h80;
   localparam logic [7:0] APM_DEF = 8'hFE;
   localparam logic [7:0] CUR_MIN = 8'h05;
   localparam logic [7:0] CUR_MAX = 8'h32;
   // Interface modes on if_mode
   localparam logic [1:0] IF_MEM = 2'h0;
   localparam logic [1:0] IF_IO = 2'h1;
   // Security and sector transfer
   localparam logic [2:0] TRIES_INIT = 3'h5;
   localparam logic [7:0] LAST_WORD = 8'hFF;
   localparam logic [7:0] PW_FIRST = 8'h01;
   localparam logic [7:0] PW_LAST = 8'h10;
   localparam int unsigned PW_WORDS = 16;

   typedef enum logic {ATASF_MDMA, ATASF_UDMA} atasf_dma_e;
   typedef enum logic [1:0] {ATASF_IDLE, ATASF_XFER, ATASF_FLUSH} atasf_state_e;

   typedef struct packed {
      logic eight_bit;
      logic wcache;
      logic [2:0] pio_mode;
      logic iordy_dis;
      atasf_dma_e dma_type;
      logic [2:0] dma_mode;
      logic apm_en;
      logic [7:0] apm_level;
      logic lookahead;
      logic revert;
      logic [7:0] cur_lim;
      logic ecc4;
      logic ext_pwr;
      logic pl1;
   } atasf_cfg_s;

   localparam atasf_cfg_s CFG_DEFAULT = '{eight_bit: 1'b0, wcache: 1'b1, pio_mode: 3'h0,
      iordy_dis: 1'b0, dma_type: ATASF_MDMA, dma_mode: 3'h0, apm_en: 1'b0, apm_level: APM_DEF,
      lookahead: 1'b0, revert: 1'b1, cur_lim: CUR_MAX, ecc4: 1'b1, ext_pwr: 1'b0, pl1: 1'b0};
endpackage
